// >>> hdl/pcstk_pkg.sv
// Purpose: types for the program counter and return stack
// Assumes: constants come from pcstk_regs.svh
// Notes: op codes are one-hot
`include "pcstk_regs.svh"
package pcstk_pkg;
  typedef logic [`PCSTK_PC_W-1:0] pcstk_pc_t;
  typedef enum logic [6:0] {
    PCSTK_OP_NEXT   = 7'h01,
    PCSTK_OP_WR_LOW = 7'h02,
    PCSTK_OP_CALL   = 7'h04,
    PCSTK_OP_JUMP   = 7'h08,
    PCSTK_OP_RETURN = 7'h10,
    PCSTK_OP_INTR   = 7'h20,
    PCSTK_OP_HOLD   = 7'h40
  } pcstk_op_e;
endpackage : pcstk_pkg

// >>> hdl/pcstk_regs.svh
// Purpose: constants for the program counter and return stack
// Assumes: one core clock, synchronous reset
// Notes: definitions only
`ifndef PCSTK_REGS_SVH
`define PCSTK_REGS_SVH
`define PCSTK_PC_W 13
`define PCSTK_LATCH_W 8
`define PCSTK_DEPTH 8
`define PCSTK_PTR_W 3
`define PCSTK_ADDR_W 11
`define PCSTK_PC_RESET 13'h0000
`define PCSTK_PTR_RESET 3'h0
`define PCSTK_LATCH_RESET 8'h00
`define PCSTK_INT_VECTOR 13'h0004
`endif

// >>> hdl/pcstk_stack.sv
// Purpose: eight-entry circular return stack
// Assumes: push and pop never together
// Notes: pointer hidden from software, wraps silently
`timescale 1ns/1ps
`include "pcstk_regs.svh"
module pcstk_stack (
  input wire logic clk_i, // core clock
  input wire logic reset_i, // synchronous reset
  pcstk_stack_if.mem stk // push/pop channel
);
  pcstk_pkg::pcstk_pc_t mem [`PCSTK_DEPTH];
  logic [`PCSTK_PTR_W-1:0] ptr;
  logic [`PCSTK_PTR_W-1:0] top_idx;

  assign top_idx = ptr - 3'h1;
  assign stk.top_data = mem[top_idx];

  // pointer wraps modulo eight, no overflow flag
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      ptr <= `PCSTK_PTR_RESET;
    else if (stk.push)
      ptr <= ptr + 3'h1;
    else if (stk.pop)
      ptr <= ptr - 3'h1;
  end

  genvar gi;
  generate
    for (gi = 0; gi < `PCSTK_DEPTH; gi++)
    begin : g_entry
      always_ff @(posedge clk_i)
      begin
        if (stk.push && ptr == 3'(gi))
          mem[gi] <= stk.push_data; // ninth push overwrites first
      end
    end
  endgenerate

  a_ptr_wrap: assert property (@(posedge clk_i) disable iff (reset_i)
    stk.push && !stk.pop |=> ptr == $past(ptr) + 3'h1)
    else $error("stack pointer did not advance on push");
  a_push_store: assert property (@(posedge clk_i) disable iff (reset_i)
    stk.push && !stk.pop |=> stk.top_data == $past(stk.push_data))
    else $error("pushed value not on top");
  c_push_nine: cover property (@(posedge clk_i) disable iff (reset_i)
    (stk.push && ptr == 3'h7) ##[1:4] stk.push);
endmodule : pcstk_stack

// >>> hdl/pcstk_stack_if.sv
// Purpose: push and pop channel between sequencer and stack memory
// Assumes: single clock
// Notes: pop data is the current top entry
`timescale 1ns/1ps
`include "pcstk_regs.svh"
interface pcstk_stack_if;
  logic push;
  logic pop;
  pcstk_pkg::pcstk_pc_t push_data;
  pcstk_pkg::pcstk_pc_t top_data;
  modport seq (output push, output pop, output push_data, input top_data);
  modport mem (input push, input pop, input push_data, output top_data);
endinterface : pcstk_stack_if

// >>> hdl/pcstk_top.sv
// Purpose: program counter sequencing with hardware return stack
// Assumes: decoder issues one op per instruction step
// Notes: low-byte register reads and writes go through ports
// Overview of operation
// - thirteen-bit counter, low byte software visible
// - upper bits loaded from holding latch, stack top or interrupt vector
// - any reset clears the whole counter
// - low byte write loads latch bits 4:0
// - call/jump take latch bits 4:3 only
// - low byte write leaves latch untouched
// - eight entries of thirteen bits
// - stack and pointer hidden from software
// - push on call and interrupt vectoring
// - pop on any return kind
// - push/pop leave holding latch alone
// - stack wraps circularly after eight pushes
// - no overflow or underflow status
`timescale 1ns/1ps
`include "pcstk_regs.svh"
module pcstk_top (
  input wire logic clk_i, // core clock 200 MHz
  input wire logic reset_i, // any reset source
  input wire logic step_i, // one instruction step, op valid
  input wire pcstk_pkg::pcstk_op_e op_i, // sequencing op
  input wire logic [`PCSTK_ADDR_W-1:0] addr_i, // instruction address field
  input wire logic [7:0] low_wdata_i, // value written to low byte
  input wire logic latch_we_i, // write to holding latch
  input wire logic [7:0] latch_wdata_i, // holding latch write data
  output logic [`PCSTK_PC_W-1:0] pc_o, // program counter
  output logic [7:0] pc_low_register_o, // low byte read value
  output logic [7:0] pc_high_holding_latch_o // holding latch read value
);
  pcstk_stack_if stk ();
  pcstk_pkg::pcstk_pc_t pc;
  pcstk_pkg::pcstk_pc_t next_pc;
  logic [7:0] pc_high_holding_latch;
  logic [4:0] pc_upper_bits;

  pcstk_stack u_stack (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .stk(stk)
  );

  assign pc_upper_bits = pc[12:8];
  assign pc_o = pc;
  assign pc_low_register_o = pc[7:0];
  assign pc_high_holding_latch_o = pc_high_holding_latch;

  // stack hooks: return address is the next instruction
  assign stk.push = step_i && (op_i == pcstk_pkg::PCSTK_OP_CALL
                    || op_i == pcstk_pkg::PCSTK_OP_INTR);
  assign stk.pop = step_i && op_i == pcstk_pkg::PCSTK_OP_RETURN;
  assign stk.push_data = pc + 13'h0001;

  always_comb
  begin
    next_pc = pc;
    if (step_i)
    begin
      case (op_i)
        pcstk_pkg::PCSTK_OP_NEXT:
          next_pc = pc + 13'h0001;
        pcstk_pkg::PCSTK_OP_WR_LOW:
          // upper bits from latch bits 4:0 above the written byte; latch not bumped
          next_pc = {pc_high_holding_latch[4:0], low_wdata_i};
        pcstk_pkg::PCSTK_OP_CALL,
        pcstk_pkg::PCSTK_OP_JUMP:
          next_pc = {pc_high_holding_latch[4:3], addr_i};
        pcstk_pkg::PCSTK_OP_RETURN:
          next_pc = stk.top_data;
        pcstk_pkg::PCSTK_OP_INTR:
          next_pc = `PCSTK_INT_VECTOR;
        pcstk_pkg::PCSTK_OP_HOLD:
          next_pc = pc;
        default:
          next_pc = pc;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      pc <= `PCSTK_PC_RESET;
    else
      pc <= next_pc;
  end

  // only software writes and reset touch the latch
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      pc_high_holding_latch <= `PCSTK_LATCH_RESET;
    else if (latch_we_i)
      pc_high_holding_latch <= latch_wdata_i;
  end

  a_reset_clear: assert property (@(posedge clk_i)
    reset_i |=> pc_o == 13'h0000)
    else $error("counter not cleared by reset");
  a_low_write: assert property (@(posedge clk_i) disable iff (reset_i)
    step_i && op_i == pcstk_pkg::PCSTK_OP_WR_LOW |=>
    pc_o == {$past(pc_high_holding_latch_o[4:0]), $past(low_wdata_i)})
    else $error("low write did not load all 13 bits");
  a_call_jump: assert property (@(posedge clk_i) disable iff (reset_i)
    step_i && (op_i == pcstk_pkg::PCSTK_OP_CALL || op_i == pcstk_pkg::PCSTK_OP_JUMP) |=>
    pc_o == {$past(pc_high_holding_latch_o[4:3]), $past(addr_i)})
    else $error("call/jump target wrong");
  a_increment: assert property (@(posedge clk_i) disable iff (reset_i)
    step_i && op_i == pcstk_pkg::PCSTK_OP_NEXT |=> pc_o == $past(pc_o) + 13'h0001)
    else $error("counter did not increment");
  a_call_return: assert property (@(posedge clk_i) disable iff (reset_i)
    // decoder leaves one idle cycle between instruction steps
    step_i && op_i == pcstk_pkg::PCSTK_OP_CALL ##1 !step_i ##1
    step_i && op_i == pcstk_pkg::PCSTK_OP_RETURN |=> pc_o == $past(pc_o, 3) + 13'h0001)
    else $error("return did not restore call address");
  a_latch_kept: assert property (@(posedge clk_i) disable iff (reset_i)
    !latch_we_i |=> $stable(pc_high_holding_latch_o))
    else $error("holding latch changed without write");
  a_intr_vector: assert property (@(posedge clk_i) disable iff (reset_i)
    step_i && op_i == pcstk_pkg::PCSTK_OP_INTR |=> pc_o == `PCSTK_INT_VECTOR)
    else $error("interrupt did not vector");
  a_upper_src: assert property (@(posedge clk_i) disable iff (reset_i)
    !step_i |=> $stable(pc_upper_bits))
    else $error("upper bits changed without an op");
  c_call_ret: cover property (@(posedge clk_i) disable iff (reset_i)
    step_i && op_i == pcstk_pkg::PCSTK_OP_CALL ##[1:20]
    step_i && op_i == pcstk_pkg::PCSTK_OP_RETURN);
  c_low_wrap: cover property (@(posedge clk_i) disable iff (reset_i)
    step_i && op_i == pcstk_pkg::PCSTK_OP_WR_LOW && pc_o[7:0] == 8'hFF && low_wdata_i == 8'h00);
  c_intr: cover property (@(posedge clk_i) disable iff (reset_i)
    step_i && op_i == pcstk_pkg::PCSTK_OP_INTR);
endmodule : pcstk_top

// >>> tb/pcstk_dec_model.sv
// Purpose: decoder-side model issuing one op per instruction step
// Assumes: inputs change on the falling edge
// Notes: idle address and data lines show the inverse of the last value
`timescale 1ns/1ps
`include "pcstk_regs.svh"
module pcstk_dec_model (
  input wire logic clk_i, // core clock
  output logic step_o, // op valid pulse
  output pcstk_pkg::pcstk_op_e op_o, // sequencing op
  output logic [`PCSTK_ADDR_W-1:0] addr_o, // address field
  output logic [7:0] wdata_o // low byte value
);
  initial
  begin
    step_o = 1'b0;
    op_o = pcstk_pkg::PCSTK_OP_HOLD;
    addr_o = 11'h000;
    wdata_o = 8'h00;
  end
  task automatic issue(input pcstk_pkg::pcstk_op_e op, input logic [10:0] a,
                       input logic [7:0] d);
    @(negedge clk_i);
    step_o = 1'b1;
    op_o = op;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    step_o = 1'b0;
    // stale values would hide a missed qualifier
    addr_o = ~a;
    wdata_o = ~d;
  endtask : issue
endmodule : pcstk_dec_model

// >>> tb/program_counter_and_call_stack_tb.sv
// Purpose: self-checking bench for the counter and return stack
// Assumes: decoder model drives ops, bench drives latch and reset
// Notes: checks are made half a cycle after the taking edge, except the pc check after the hold op, made two and a half cycles after
`timescale 1ns/1ps
`include "pcstk_regs.svh"
module program_counter_and_call_stack_tb;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic latch_we = 1'b0;
  logic [7:0] latch_d = 8'h00;
  logic step;
  pcstk_pkg::pcstk_op_e op;
  logic [10:0] addr;
  logic [7:0] wd, lo, lat;
  logic [12:0] pc;
  int n_mismatch = 0;
  int checks_done = 0;
  always #2.5 clk_i = ~clk_i;
  pcstk_dec_model u_dec (.clk_i(clk_i), .step_o(step), .op_o(op), .addr_o(addr), .wdata_o(wd));
  pcstk_top dut (.clk_i(clk_i), .reset_i(reset_i), .step_i(step), .op_i(op), .addr_i(addr),
    .low_wdata_i(wd), .latch_we_i(latch_we), .latch_wdata_i(latch_d), .pc_o(pc),
    .pc_low_register_o(lo), .pc_high_holding_latch_o(lat));
  task automatic chk(input string name, input logic [12:0] seen, input logic [12:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic set_latch(input logic [7:0] v);
    @(negedge clk_i);
    latch_we = 1'b1;
    latch_d = v;
    @(negedge clk_i);
    latch_we = 1'b0;
    latch_d = ~v;
  endtask : set_latch
  task automatic t_low();
    chk("pc", pc, 13'h0000);
    set_latch(8'hF5);
    u_dec.issue(pcstk_pkg::PCSTK_OP_WR_LOW, 11'h000, 8'hAB);
    chk("pc", pc, 13'h15AB);
    chk("low", {5'h00, lo}, 13'h00AB);
    u_dec.issue(pcstk_pkg::PCSTK_OP_WR_LOW, 11'h000, 8'hFF);
    u_dec.issue(pcstk_pkg::PCSTK_OP_NEXT, 11'h000, 8'h00);
    chk("pc", pc, 13'h1600);
    u_dec.issue(pcstk_pkg::PCSTK_OP_WR_LOW, 11'h000, 8'h03);
    chk("pc", pc, 13'h1503);
    chk("latch", {5'h00, lat}, 13'h00F5);
    u_dec.issue(pcstk_pkg::PCSTK_OP_HOLD, 11'h000, 8'h00);
    repeat (2) @(negedge clk_i);
    chk("pc", pc, 13'h1503);
    reset_i = 1'b1;
    @(negedge clk_i);
    reset_i = 1'b0;
    chk("pc", pc, 13'h0000);
    chk("latch", {5'h00, lat}, 13'h0000);
    $display("t_low done");
  endtask : t_low
  task automatic t_call();
    set_latch(8'h18);
    u_dec.issue(pcstk_pkg::PCSTK_OP_WR_LOW, 11'h000, 8'h10);
    u_dec.issue(pcstk_pkg::PCSTK_OP_CALL, 11'h123, 8'h00);
    chk("pc", pc, 13'h1923);
    chk("latch", {5'h00, lat}, 13'h0018);
    u_dec.issue(pcstk_pkg::PCSTK_OP_RETURN, 11'h000, 8'h00);
    chk("pc", pc, 13'h1811);
    u_dec.issue(pcstk_pkg::PCSTK_OP_JUMP, 11'h7FF, 8'h00);
    chk("pc", pc, 13'h1FFF);
    u_dec.issue(pcstk_pkg::PCSTK_OP_NEXT, 11'h000, 8'h00);
    chk("pc", pc, 13'h0000);
    u_dec.issue(pcstk_pkg::PCSTK_OP_INTR, 11'h000, 8'h00);
    chk("pc", pc, 13'h0004);
    u_dec.issue(pcstk_pkg::PCSTK_OP_RETURN, 11'h000, 8'h00);
    chk("pc", pc, 13'h0001);
    chk("latch", {5'h00, lat}, 13'h0018);
    $display("t_call done");
  endtask : t_call
  task automatic t_circ();
    int k;
    u_dec.issue(pcstk_pkg::PCSTK_OP_JUMP, 11'h000, 8'h00);
    for (int i = 1; i <= 9; i++)
    begin
      u_dec.issue(pcstk_pkg::PCSTK_OP_CALL, 11'(i * 16), 8'h00);
    end
    // ninth push lands on the first slot, so the last pop sees it again
    for (int j = 0; j <= 8; j++)
    begin
      k = (j < 8) ? 9 - j : 9;
      u_dec.issue(pcstk_pkg::PCSTK_OP_RETURN, 11'h000, 8'h00);
      chk("pop", pc, 13'(13'h1801 + (k - 1) * 16));
    end
    $display("t_circ done");
  endtask : t_circ
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    t_low();
    t_call();
    t_circ();
    report_and_stop();
  end
endmodule : program_counter_and_call_stack_tb
